// ---- verilog/gpio78_pkg.sv ----
// gpio78_pkg: register map, field masks and carrier types for the port 7 / port 8 block.
// assumes a 32-bit AXI4-Lite slave with one aligned word per register.
package gpio78_pkg;

  localparam int unsigned AW = 5;

  // register byte addresses
  localparam logic [AW-1:0] OFS_P7_DIR  = 5'h00;
  localparam logic [AW-1:0] OFS_P7_DATA = 5'h04;
  localparam logic [AW-1:0] OFS_P8_DIR  = 5'h08;
  localparam logic [AW-1:0] OFS_P8_DATA = 5'h0c;
  localparam logic [AW-1:0] OFS_ALT_CFG = 5'h10;

  // implemented bits and read-as-one reserved bits
  localparam logic [7:0] P7_IMPL_MASK = 8'h77;
  localparam logic [7:0] P7_RSVD_ONES = 8'h88;
  localparam logic [7:0] P8_IMPL_MASK = 8'he0;
  localparam logic [7:0] P8_RSVD_ONES = 8'h1f;
  localparam logic [7:0] DIR_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  // alternate-function config register fields
  localparam int unsigned ALT_TMO_SEL_LSB = 0;
  localparam int unsigned ALT_TXE_BIT     = 4;
  localparam int unsigned ALT_RXE_BIT     = 5;
  localparam int unsigned ALT_SCK_EXT_BIT = 6;
  localparam int unsigned ALT_SCK_INT_BIT = 7;
  localparam int unsigned ALT_SYNC_BIT    = 8;
  localparam logic [8:0]  ALT_CFG_RESET = 9'h000;

  // port 7 bit positions
  localparam int unsigned P7_TMO_BIT = 6;
  localparam int unsigned P7_TCK_BIT = 5;
  localparam int unsigned P7_TRS_BIT = 4;
  localparam int unsigned P7_TXD_BIT = 2;
  localparam int unsigned P7_RXD_BIT = 1;
  localparam int unsigned P7_SCK_BIT = 0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } pin_drive_s;

  // first member is the msb: order mirrors bits 8 down to 0 of the config word
  typedef struct packed {
    logic       sync_mode;
    logic       sck_int;
    logic       sck_ext;
    logic       rx_en;
    logic       tx_en;
    logic [3:0] tmo_sel;
  } alt_cfg_s;

endpackage : gpio78_pkg

// ---- verilog/gpio_port7_port8.sv ----
// gpio_port7_port8: two byte-wide I/O ports with direction and data latches,
// AXI4-Lite register access, and port 7 alternate-function override.
// assumes pin inputs are synchronous to CLK_I; tristate wires are resolved outside.
`timescale 1ns/1ps
`default_nettype none

module gpio_port7_port8
  import gpio78_pkg::*;
(
  // clock and reset
  input  wire logic                     CLK_I,
  input  wire logic                     RST_N_I,
  // axi4-lite write address, data and response
  input  wire logic [gpio78_pkg::AW-1:0] AWADDR_I,
  input  wire logic                     AWVALID_I,
  output logic                          AWREADY_O,
  input  wire logic [31:0]              WDATA_I,
  input  wire logic [3:0]               WSTRB_I,
  input  wire logic                     WVALID_I,
  output logic                          WREADY_O,
  output logic [1:0]                    BRESP_O,
  output logic                          BVALID_O,
  input  wire logic                     BREADY_I,
  // axi4-lite read
  input  wire logic [gpio78_pkg::AW-1:0] ARADDR_I,
  input  wire logic                     ARVALID_I,
  output logic                          ARREADY_O,
  output logic [31:0]                   RDATA_O,
  output logic [1:0]                    RRESP_O,
  output logic                          RVALID_O,
  input  wire logic                     RREADY_I,
  // port pins
  input  wire logic [7:0]               P7_IN_I,
  output logic [7:0]                    P7_OUT_O,
  output logic [7:0]                    P7_OE_O,
  input  wire logic [7:0]               P8_IN_I,
  output logic [7:0]                    P8_OUT_O,
  output logic [7:0]                    P8_OE_O,
  // alternate-function peripherals
  input  wire logic                     TIMER_OUT_I,
  output logic                          TIMER_CLK_O,
  output logic                          TIMER_RST_O,
  input  wire logic                     SERIAL_TXD_I,
  output logic                          SERIAL_RXD_O,
  input  wire logic                     SERIAL_SCK_I,
  output logic                          SERIAL_SCK_O
);
  import gpio78_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] p7_dir_r, p7_data_r, p8_dir_r, p8_data_r;
  logic [8:0] alt_r;
  alt_cfg_s   alt;
  assign alt = alt_cfg_s'(alt_r);

  // read-back mux: latch where output, live pin where input
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] lat,
                                           input logic [7:0] pin, input logic [7:0] impl,
                                           input logic [7:0] ones);
    port_read = (((dir & lat) | (~dir & pin)) & impl) | ones;
  endfunction : port_read

  // offset decode used by the write channel and by the read-channel error check
  function automatic logic reg_mapped(input logic [AW-1:0] a);
    reg_mapped = (a == OFS_P7_DIR) || (a == OFS_P7_DATA) || (a == OFS_P8_DIR) ||
                 (a == OFS_P8_DATA) || (a == OFS_ALT_CFG);
  endfunction : reg_mapped

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data accepted in either order
  logic            aw_held_r, w_held_r;
  logic [AW-1:0]   aw_addr_r;
  logic [31:0]     w_data_r;
  logic [3:0]      w_strb_r;
  logic            bvalid_r;
  logic [1:0]      bresp_r;
  logic            wr_go;
  logic [AW-1:0]   wa;
  logic [31:0]     wd;
  logic [3:0]      ws;

  assign AWREADY_O = !aw_held_r && !bvalid_r;
  assign WREADY_O  = !w_held_r && !bvalid_r;
  assign wa = aw_held_r ? aw_addr_r : AWADDR_I;
  assign wd = w_held_r ? w_data_r : WDATA_I;
  assign ws = w_held_r ? w_strb_r : WSTRB_I;
  assign wr_go = (aw_held_r || (AWVALID_I && AWREADY_O)) &&
                 (w_held_r || (WVALID_I && WREADY_O));

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_held_r <= 1'b1;
        w_data_r <= WDATA_I;
        w_strb_r <= WSTRB_I;
      end
    end
  end

  logic wr_hit;
  assign wr_hit = reg_mapped(wa);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY_I) begin
      bvalid_r <= 1'b0;
    end
  end
  assign BVALID_O = bvalid_r;
  assign BRESP_O  = bresp_r;

  // register writes; unimplemented bits never store
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      p7_dir_r  <= DIR_RESET;
      p7_data_r <= DATA_RESET;
      p8_dir_r  <= DIR_RESET;
      p8_data_r <= DATA_RESET;
      alt_r     <= ALT_CFG_RESET;
    end else if (wr_go) begin
      if (ws[0] && wa == OFS_P7_DIR)  p7_dir_r  <= wd[7:0] & P7_IMPL_MASK;
      if (ws[0] && wa == OFS_P7_DATA) p7_data_r <= wd[7:0] & P7_IMPL_MASK;
      if (ws[0] && wa == OFS_P8_DIR)  p8_dir_r  <= wd[7:0] & P8_IMPL_MASK;
      if (ws[0] && wa == OFS_P8_DATA) p8_data_r <= wd[7:0] & P8_IMPL_MASK;
      if (wa == OFS_ALT_CFG) begin
        if (ws[0]) alt_r[7:0] <= wd[7:0];
        if (ws[1]) alt_r[8]   <= wd[8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel; direction registers are write-only and read as zero
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  assign ARREADY_O = !rvalid_r;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= '0;
      unique case (ARADDR_I)
        OFS_P7_DIR, OFS_P8_DIR: rdata_r <= '0;
        OFS_P7_DATA: rdata_r[7:0] <= port_read(p7_dir_r, p7_data_r, P7_IN_I,
                                                P7_IMPL_MASK, P7_RSVD_ONES);
        OFS_P8_DATA: rdata_r[7:0] <= port_read(p8_dir_r, p8_data_r, P8_IN_I,
                                                P8_IMPL_MASK, P8_RSVD_ONES);
        OFS_ALT_CFG: rdata_r[8:0] <= alt_r;
        default:     rresp_r <= RESP_SLVERR;
      endcase
    end else if (RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end
  assign RVALID_O = rvalid_r;
  assign RDATA_O  = rdata_r;
  assign RRESP_O  = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: alternate functions take priority over general I/O
  pin_drive_s p7_drv;
  logic       tmo_on, sck_out, sck_in;
  assign tmo_on  = alt.tmo_sel != 4'h0;
  assign sck_in  = alt.sck_ext;
  assign sck_out = !alt.sck_ext && (alt.sck_int || alt.sync_mode);

  always_comb begin
    p7_drv.o  = p7_data_r & P7_IMPL_MASK;
    p7_drv.oe = p7_dir_r & P7_IMPL_MASK;
    if (tmo_on) begin
      p7_drv.o[P7_TMO_BIT]  = TIMER_OUT_I;
      p7_drv.oe[P7_TMO_BIT] = 1'b1;
    end
    if (alt.tx_en) begin
      p7_drv.o[P7_TXD_BIT]  = SERIAL_TXD_I;
      p7_drv.oe[P7_TXD_BIT] = 1'b1;
    end
    if (alt.rx_en) begin
      p7_drv.o[P7_RXD_BIT]  = 1'b0;
      p7_drv.oe[P7_RXD_BIT] = 1'b0;
    end
    if (sck_out) begin
      p7_drv.o[P7_SCK_BIT]  = SERIAL_SCK_I;
      p7_drv.oe[P7_SCK_BIT] = 1'b1;
    end else if (sck_in) begin
      p7_drv.o[P7_SCK_BIT]  = 1'b0;
      p7_drv.oe[P7_SCK_BIT] = 1'b0;
    end
  end

  assign P7_OUT_O = p7_drv.o;
  assign P7_OE_O  = p7_drv.oe;
  assign P8_OUT_O = p8_data_r & P8_IMPL_MASK;
  assign P8_OE_O  = p8_dir_r & P8_IMPL_MASK;

  // timer inputs stay connected even while the pins act as general I/O
  assign TIMER_CLK_O  = P7_IN_I[P7_TCK_BIT];
  assign TIMER_RST_O  = P7_IN_I[P7_TRS_BIT];
  assign SERIAL_RXD_O = P7_IN_I[P7_RXD_BIT];
  assign SERIAL_SCK_O = P7_IN_I[P7_SCK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  chk_p7_override: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    tmo_on |-> (P7_OE_O[P7_TMO_BIT] && P7_OUT_O[P7_TMO_BIT] == TIMER_OUT_I))
    else $error("timer output does not own port 7 bit 6");
  chk_p7_dir: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_go && ws[0] && wa == OFS_P7_DIR && !tmo_on && !alt.tx_en && !alt.rx_en
     && !alt.sck_ext && !alt.sck_int && !alt.sync_mode) |=>
    (P7_OE_O == ($past(wd[7:0]) & P7_IMPL_MASK)))
    else $error("port 7 direction write not reflected on enables");
  chk_p7_rsvd: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && ARADDR_I == OFS_P7_DATA) |=> (RDATA_O[7] && RDATA_O[3]))
    else $error("port 7 reserved bits not read as one");
  chk_p7_drive: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (p7_dir_r[4] |-> P7_OUT_O[4] == p7_data_r[4]))
    else $error("port 7 latch not driven");
  chk_p7_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && ARADDR_I == OFS_P7_DATA) |=>
    (RDATA_O[7:0] == ((($past(p7_dir_r) & $past(p7_data_r)) | (~$past(p7_dir_r)
      & $past(P7_IN_I))) & P7_IMPL_MASK | P7_RSVD_ONES)))
    else $error("port 7 read mux wrong");
  chk_p8_dir: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    P8_OE_O[4:0] == 5'h00)
    else $error("port 8 reserved bit driven");
  chk_p8_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && ARADDR_I == OFS_P8_DATA) |=>
    (RDATA_O[7:0] == (((($past(p8_dir_r) & $past(p8_data_r)) | (~$past(p8_dir_r)
      & $past(P8_IN_I))) & P8_IMPL_MASK) | P8_RSVD_ONES)))
    else $error("port 8 read mux wrong");
  chk_timer_in: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    TIMER_CLK_O == P7_IN_I[5] && TIMER_RST_O == P7_IN_I[4])
    else $error("timer inputs not fed from pins");
  chk_serial_pins: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (alt.tx_en |-> P7_OE_O[2]) and (alt.rx_en |-> !P7_OE_O[1]) and (sck_in |-> !P7_OE_O[0]))
    else $error("serial pin override wrong");
  chk_bresp_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (BVALID_O && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O)))
    else $error("write response dropped early");
  chk_p7_rsvd_oe: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !P7_OE_O[7] && !P7_OE_O[3])
    else $error("port 7 reserved bit driven");
  chk_tmo_release: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !tmo_on |-> (P7_OE_O[P7_TMO_BIT] == p7_dir_r[P7_TMO_BIT]))
    else $error("port 7 bit 6 direction ignored without timer claim");
  chk_p7_wr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_go && ws[0] && wa == OFS_P7_DATA) |=> (P7_OUT_O[5:4] == $past(wd[5:4])))
    else $error("port 7 data write not reflected on pins");
  chk_p7_in_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && ARADDR_I == OFS_P7_DATA && p7_dir_r == 8'h00) |=>
    (RDATA_O[7:0] == (($past(P7_IN_I) & P7_IMPL_MASK) | P7_RSVD_ONES)))
    else $error("port 7 input read not taken from pins");
  chk_p8_oe: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_go && ws[0] && wa == OFS_P8_DIR) |=> (P8_OE_O == ($past(wd[7:0]) & P8_IMPL_MASK)))
    else $error("port 8 direction write not reflected on enables");
  chk_p8_wr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_go && ws[0] && wa == OFS_P8_DATA) |=> (P8_OUT_O == ($past(wd[7:0]) & P8_IMPL_MASK)))
    else $error("port 8 data write not reflected on pins");
  chk_p8_latch_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && ARADDR_I == OFS_P8_DATA && p8_dir_r == P8_IMPL_MASK) |=>
    (RDATA_O[7:0] == ($past(p8_data_r) | P8_RSVD_ONES)))
    else $error("port 8 output read not taken from latch");
  chk_p8_rsvd: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && ARADDR_I == OFS_P8_DATA) |=>
    ((RDATA_O[7:0] & P8_RSVD_ONES) == P8_RSVD_ONES))
    else $error("port 8 reserved bits not read as one");
  chk_tx_own: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    alt.tx_en |-> (P7_OUT_O[P7_TXD_BIT] == SERIAL_TXD_I))
    else $error("serial transmit does not own port 7 bit 2");
  chk_sck_own: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    sck_out |-> (P7_OE_O[P7_SCK_BIT] && P7_OUT_O[P7_SCK_BIT] == SERIAL_SCK_I))
    else $error("serial clock does not own port 7 bit 0");

  // bus handshake: one-cycle answers, refusals while busy
  chk_wr_answer: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_go |=> BVALID_O)
    else $error("write response late");
  chk_wr_slverr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (wr_go && !wr_hit) |=> (BRESP_O == RESP_SLVERR))
    else $error("unmapped write not flagged");
  chk_wr_refuse: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    BVALID_O |-> (!AWREADY_O && !WREADY_O))
    else $error("write accepted while response pending");
  chk_rd_answer: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O) |=> RVALID_O)
    else $error("read response late");
  chk_rd_slverr: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ARVALID_I && ARREADY_O && !reg_mapped(ARADDR_I)) |=> (RRESP_O == RESP_SLVERR))
    else $error("unmapped read not flagged");
  chk_rdata_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (RVALID_O && !RREADY_I) |=> (RVALID_O && $stable(RDATA_O) && $stable(RRESP_O)))
    else $error("read response dropped early");

  cov_p7_write: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    wr_go && wa == OFS_P7_DATA);
  cov_p8_read: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    RVALID_O && RREADY_I && RDATA_O[7:5] != 3'h0);
  cov_tmo: cover property (@(posedge CLK_I) disable iff (!RST_N_I) tmo_on && p7_dir_r[6]);
  cov_sck_out: cover property (@(posedge CLK_I) disable iff (!RST_N_I) sck_out);
  cov_alt_read: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    RVALID_O && RREADY_I && RDATA_O[8] && RRESP_O == RESP_OKAY);

endmodule : gpio_port7_port8

`default_nettype wire

// ---- bench/gpio_port7_port8_bench.sv ----
// gpio_port7_port8_bench: self-checking bench for the port 7 / port 8 block.
// assumes the design's own assertions; drives AXI4-Lite and pins directly.
`timescale 1ns/1ps
`default_nettype none
module gpio_port7_port8_bench;
  import gpio78_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [AW-1:0] aw_addr = '0, ar_addr = '0;
  logic [31:0] w_data = '0;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic [7:0] p7_in = 8'haa, p8_in = 8'h55;
  logic tmr_out = 1'b1, txd = 1'b1, sck = 1'b1;
  wire logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, tclk, trst, rxd, sck_o;
  wire logic [1:0] b_resp, r_resp;
  wire logic [31:0] r_data;
  wire logic [7:0] p7_out, p7_oe, p8_out, p8_oe;
  int miscompares = 0, checks = 0, cycles = 0;
  // cfg, expected enable, expected driven value with base dir 77 data 00
  localparam logic [24:0] ALT_TAB [8] = '{
    {9'h001, 8'h77, 8'h40}, {9'h00f, 8'h77, 8'h40}, {9'h010, 8'h77, 8'h04},
    {9'h020, 8'h75, 8'h00}, {9'h040, 8'h76, 8'h00}, {9'h080, 8'h77, 8'h01},
    {9'h100, 8'h77, 8'h01}, {9'h000, 8'h77, 8'h00}};
  always #2.5 clk = ~clk;
  gpio_port7_port8 gpio_port7_port8_inst (
    .CLK_I(clk), .RST_N_I(rst_n),
    .AWADDR_I(aw_addr), .AWVALID_I(aw_valid), .AWREADY_O(aw_rdy),
    .WDATA_I(w_data), .WSTRB_I(4'hf), .WVALID_I(w_valid), .WREADY_O(w_rdy),
    .BRESP_O(b_resp), .BVALID_O(b_vld), .BREADY_I(b_ready),
    .ARADDR_I(ar_addr), .ARVALID_I(ar_valid), .ARREADY_O(ar_rdy),
    .RDATA_O(r_data), .RRESP_O(r_resp), .RVALID_O(r_vld), .RREADY_I(r_ready),
    .P7_IN_I(p7_in), .P7_OUT_O(p7_out), .P7_OE_O(p7_oe),
    .P8_IN_I(p8_in), .P8_OUT_O(p8_out), .P8_OE_O(p8_oe),
    .TIMER_OUT_I(tmr_out), .TIMER_CLK_O(tclk), .TIMER_RST_O(trst),
    .SERIAL_TXD_I(txd), .SERIAL_RXD_O(rxd), .SERIAL_SCK_I(sck), .SERIAL_SCK_O(sck_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // handshakes are judged at the negedge before the edge that takes them;
  // inputs only move at posedges, so the ready seen there holds at the edge
  task automatic axi_wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, aw_done, w_done, b_hit;
    logic [1:0] resp;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_hit = 1'b0;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk);
      aw_hit = aw_valid && aw_rdy;
      w_hit = w_valid && w_rdy;
      @(posedge clk);
      if (aw_hit) begin aw_valid <= 1'b0; aw_done = 1'b1; end
      if (w_hit) begin w_valid <= 1'b0; w_done = 1'b1; end
    end
    b_ready <= 1'b1;
    while (!b_hit) begin
      @(negedge clk);
      b_hit = b_vld;
      resp = b_resp;
      @(posedge clk);
    end
    b_ready <= 1'b0;
    chk({30'h0, resp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic hit, r_hit;
    logic [31:0] d;
    logic [1:0] resp;
    hit = 1'b0;
    r_hit = 1'b0;
    ar_addr <= a;
    ar_valid <= 1'b1;
    while (!hit) begin
      @(negedge clk);
      hit = ar_rdy;
      @(posedge clk);
    end
    ar_valid <= 1'b0;
    r_ready <= 1'b1;
    while (!r_hit) begin
      @(negedge clk);
      r_hit = r_vld;
      d = r_data;
      resp = r_resp;
      @(posedge clk);
    end
    r_ready <= 1'b0;
    chk(d, ed);
    chk({30'h0, resp}, {30'h0, er});
  endtask : axi_rd
  task automatic pins(input logic [7:0] oe7, input logic [7:0] out7, input logic [7:0] oe8);
    @(negedge clk);
    chk({24'h0, p7_oe}, {24'h0, oe7});
    chk({24'h0, p7_out & p7_oe}, {24'h0, out7});
    chk({24'h0, p8_oe}, {24'h0, oe8});
    @(posedge clk);
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axi_rd(OFS_P7_DIR, 32'h0, RESP_OKAY);
    axi_rd(OFS_P7_DATA, 32'haa, RESP_OKAY);
    axi_rd(OFS_P8_DATA, 32'h5f, RESP_OKAY);
    pins(8'h00, 8'h00, 8'h00);
    axi_wr(OFS_P7_DIR, 32'h77, RESP_OKAY);
    axi_rd(OFS_P7_DATA, 32'h88, RESP_OKAY);
    axi_wr(OFS_P8_DIR, 32'he0, RESP_OKAY);
    axi_rd(OFS_P8_DATA, 32'h1f, RESP_OKAY);
    $display("test reset_values done");
    axi_wr(OFS_P7_DATA, 32'h55, RESP_OKAY);
    axi_rd(OFS_P7_DATA, 32'hdd, RESP_OKAY);
    pins(8'h77, 8'h55, 8'he0);
    axi_wr(OFS_P7_DIR, 32'h0f, RESP_OKAY);
    axi_rd(OFS_P7_DATA, 32'had, RESP_OKAY);
    pins(8'h07, 8'h05, 8'he0);
    $display("test port7_data done");
    p8_in <= 8'h80;
    axi_wr(OFS_P8_DATA, 32'ha0, RESP_OKAY);
    axi_rd(OFS_P8_DATA, 32'hbf, RESP_OKAY);
    pins(8'h07, 8'h05, 8'he0);
    chk({24'h0, p8_out & p8_oe}, 32'ha0);
    axi_wr(OFS_P8_DIR, 32'h40, RESP_OKAY);
    axi_rd(OFS_P8_DATA, 32'h9f, RESP_OKAY);
    pins(8'h07, 8'h05, 8'h40);
    $display("test port8_data done");
    axi_wr(OFS_P7_DIR, 32'h77, RESP_OKAY);
    axi_wr(OFS_P7_DATA, 32'h00, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      axi_wr(OFS_ALT_CFG, {23'h0, ALT_TAB[i][24:16]}, RESP_OKAY);
      axi_rd(OFS_ALT_CFG, {23'h0, ALT_TAB[i][24:16]}, RESP_OKAY);
      pins(ALT_TAB[i][15:8], ALT_TAB[i][7:0], 8'h40);
    end
    $display("test alt_override done");
    p7_in <= 8'h31;
    @(posedge clk);
    @(negedge clk);
    chk({28'h0, tclk, trst, rxd, sck_o}, 32'hd);
    @(posedge clk);
    p7_in <= 8'h22;
    @(posedge clk);
    @(negedge clk);
    chk({28'h0, tclk, trst, rxd, sck_o}, 32'ha);
    @(posedge clk);
    $display("test alt_inputs done");
    // unmapped word just past the alternate config register
    axi_wr(5'h14, 32'hff, RESP_SLVERR);
    axi_rd(5'h14, 32'h0, RESP_SLVERR);
    axi_rd(OFS_P8_DIR, 32'h0, RESP_OKAY);
    $display("test unmapped done");
    summarize();
  end
endmodule : gpio_port7_port8_bench
`default_nettype wire
